// ---- common/pgs_defines.svh ----
// register offsets, field positions and reset values for the gigabit status block
`ifndef PGS_DEFINES_SVH
`define PGS_DEFINES_SVH
`define PGS_IDX_GIG_STATUS 5'h0a
`define PGS_IDX_ACC_CTRL 5'h0d
`define PGS_IDX_ADDR_DATA 5'h0e
`define PGS_IDX_GIG_EXT1 5'h0f
`define PGS_IDX_FAST_EXT 5'h10
`define PGS_IDX_PAGE_SEL 5'h1f
`define PGS_FN_ADDR 2'h0
`define PGS_FN_DATA 2'h1
`define PGS_FN_DATA_INC_RW 2'h2
`define PGS_FN_DATA_INC_WR 2'h3
`define PGS_FN_HI 15
`define PGS_FN_LO 14
`define PGS_DEVAD_HI 4
`define PGS_DEVAD_LO 0
`define PGS_EXT1_VALUE 16'h3000
`define PGS_RST_ADDR_DATA 16'h0000
`define PGS_RST_CTRL 16'h0000
`define PGS_PAGE_MAX 2'h2
`endif

// ---- common/pgs_pkg.sv ----
// types for the gigabit status and indirect access register block
package pgs_pkg;
   typedef struct packed {
      logic ms_fault;
      logic ms_master;
      logic local_rx_ok;
      logic remote_rx_ok;
      logic lp_1000_fd;
      logic lp_1000_hd;
      logic idle_err;
   } pgs_gig_evt_s;
   typedef struct packed {
      logic desc_locked;
      logic lock_err;
      logic link_disc;
      logic link_up;
      logic rx_err;
      logic tx_err;
      logic ssd_err;
      logic esd_err;
   } pgs_fast_evt_s;
   typedef struct packed {
      logic [15:0] addr;
      logic [4:0] devad;
      logic rd;
      logic wr;
      logic [15:0] wdata;
   } pgs_mmd_req_s;
endpackage

// ---- sim/pgs_mmd_model.sv ----
// far-side manageable device model behind the indirect access window
`timescale 1ns/1ps
module pgs_mmd_model (
   input wire logic clk,
   input wire pgs_pkg::pgs_mmd_req_s mmd_req,
   output logic [15:0] mmd_rdata
);
   import pgs_pkg::*;
   logic [15:0] mem [int];
   int key;
   int unsigned n_wr = 0;
   // store keyed by device and register address
   always @(posedge clk) begin
      if (mmd_req.wr) begin
         mem[{11'h000, mmd_req.devad, mmd_req.addr}] = mmd_req.wdata;
         n_wr++;
      end
   end
   // answers at once for the address the block holds now
   // unwritten places answer the inverted address, so a lost write never reads back as data
   always @(mmd_req or n_wr) begin
      key = {11'h000, mmd_req.devad, mmd_req.addr};
      mmd_rdata = mem.exists(key) ? mem[key] : ~mmd_req.addr;
   end
endmodule

// ---- sim/phy_gigabit_status_mmd_access_regs_bench.sv ----
// self-checking bench for the gigabit status and indirect access register block
`timescale 1ns/1ps
module phy_gigabit_status_mmd_access_regs_bench;
   import pgs_pkg::*;
   logic clk, rst_n, cyc, stb, we, ack;
   logic [6:0] adr;
   logic [31:0] dat_i, dat_o, lv;
   logic [15:0] rdata, q, d, e;
   logic [1:0] page;
   pgs_gig_evt_s gig;
   pgs_fast_evt_s fast;
   pgs_mmd_req_s req;
   logic [15:0] mem [int];
   int errors, n_compared, cycles, k, maddr, devad;

   always #5 clk = ~clk;

   pgs_regs u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .gig_evt(gig), .fast_evt(fast), .mmd_rdata(rdata), .mmd_req(req), .page_sel(page));
   pgs_mmd_model u_mmd (.clk(clk), .mmd_req(req), .mmd_rdata(rdata));

   ////////////////////////////////////////////////////////////////////////
   task stop_test;
      if (errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one classic cycle; request held until ack is sampled high
   task bus(input logic w, input logic [6:0] a, input logic [15:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_i <= {16'h0000, wd};
      @(posedge clk);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n >= 20)
         errors++;
      q = dat_o[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task rdc(input logic [6:0] a, input logic [15:0] exp);
      bus(1'b0, a, 16'h0000);
      chk(q, exp);
   endtask

   function automatic logic [15:0] mmd_exp(int dv, int ad);
      int key;
      key = dv * 65536 + ad;
      return mem.exists(key) ? mem[key] : ~16'(ad);
   endfunction

   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         errors++;
         stop_test;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {cyc, stb, we, adr, dat_i} = '0;
      gig = '0;
      fast = '0;
      errors = 0;
      n_compared = 0;
      cycles = 0;
      void'($urandom(52046));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rdc(7'h28, 16'h0000);
      rdc(7'h34, 16'h0000);
      rdc(7'h38, 16'h0000);
      rdc(7'h3c, 16'h3000);
      rdc(7'h40, 16'h0000);
      rdc(7'h44, 16'h0000);
      // fault pulse plus idle errors, long runs reach saturation
      repeat (3) begin
         lv = $urandom;
         k = $urandom_range(2, 300);
         @(posedge clk);
         gig <= {1'b1, lv[4:0], 1'b1};
         @(posedge clk);
         gig.ms_fault <= 1'b0;
         repeat (k - 1) @(posedge clk);
         gig.idle_err <= 1'b0;
         rdc(7'h28, {1'b1, lv[4:0], 2'b00, (k > 255) ? 8'hff : 8'(k)});
         rdc(7'h28, {1'b0, lv[4:0], 10'h000});
      end
      repeat (3) begin
         lv = $urandom;
         @(posedge clk);
         fast <= lv[7:0];
         @(posedge clk);
         fast <= lv[7:0] & 8'h90;
         rdc(7'h40, {lv[7:0], 8'h00});
         rdc(7'h40, {lv[7:0] & 8'h90, 8'h00});
      end
      bus(1'b1, 7'h7c, 16'h0001);
      rdc(7'h40, 16'h0000);
      rdc(7'h3c, 16'h3000);
      bus(1'b1, 7'h7c, 16'h0003);
      chk({14'h0000, page}, 16'h0001);
      bus(1'b1, 7'h7c, 16'h0000);
      rdc(7'h40, {lv[7:0] & 8'h90, 8'h00});
      for (int fn = 0; fn < 4; fn++) begin
         devad = $urandom_range(0, 31);
         maddr = $urandom_range(0, 65535);
         d = 16'($urandom);
         bus(1'b1, 7'h34, {2'b00, 9'h1ff, 5'(devad)});
         rdc(7'h34, {11'h000, 5'(devad)});
         // address reloaded before each data write, no reliance on write increment
         bus(1'b1, 7'h38, 16'(maddr));
         bus(1'b1, 7'h34, {2'(fn), 9'h000, 5'(devad)});
         bus(1'b1, 7'h38, d);
         if (fn == 0)
            maddr = d;
         else
            mem[devad * 65536 + maddr] = d;
         if (fn >= 2)
            maddr = (maddr + 1) % 65536;
         e = (fn == 0) ? 16'(maddr) : mmd_exp(devad, maddr);
         rdc(7'h38, e);
         if (fn == 2)
            maddr = (maddr + 1) % 65536;
         bus(1'b1, 7'h34, {2'b00, 9'h000, 5'(devad)});
         rdc(7'h38, 16'(maddr));
      end
      stop_test;
   end
endmodule

// ---- verilog/pgs_regs.sv ----
// gigabit status, indirect device access and status extension registers
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`include "pgs_defines.svh"
module pgs_regs (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [6:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire pgs_pkg::pgs_gig_evt_s gig_evt,
   input wire pgs_pkg::pgs_fast_evt_s fast_evt,
   input wire logic [15:0] mmd_rdata,
   output pgs_pkg::pgs_mmd_req_s mmd_req,
   output logic [1:0] page_sel
);
   import pgs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic ms_fault;
      logic [1:0] fn;
      logic [4:0] devad;
      logic [15:0] addr_data;
      logic [15:0] mmd_addr;
      logic [1:0] page;
      pgs_mmd_req_s req;
   } pgs_regs_s;
   pgs_regs_s st_ff, nxt_st;

   logic [5:0] fast_flags;
   logic [7:0] idle_cnt;
   logic clr_fast;
   logic clr_gig;

   function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d,
                                              input logic [3:0] sel);
      lane_merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic is_data_fn(input logic [1:0] fn);
      is_data_fn = (fn != `PGS_FN_ADDR);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic req_new;
   logic is_rd;
   logic is_wr;
   logic [4:0] idx;
   logic page0;
   assign req_new = wb_cyc_i && wb_stb_i && !st_ff.ack;
   assign is_rd = req_new && !wb_we_i;
   assign is_wr = req_new && wb_we_i;
   assign idx = wb_adr_i[6:2];
   assign page0 = (st_ff.page == 2'h0);
   // read clears happen only on the accepting cycle, never on a repeat
   assign clr_gig = is_rd && idx == `PGS_IDX_GIG_STATUS;
   assign clr_fast = is_rd && idx == `PGS_IDX_FAST_EXT && page0;

   pgs_sticky #(.CNT_W(8)) u_fast (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .evt({fast_evt.lock_err, fast_evt.link_disc, fast_evt.rx_err,
            fast_evt.tx_err, fast_evt.ssd_err, fast_evt.esd_err}),
      .cnt_inc(gig_evt.idle_err),
      .clr_flags(clr_fast),
      .clr_cnt(clr_gig),
      .flags(fast_flags),
      .count(idle_cnt)
   );

   ////////////////////////////////////////////////////////////////////////
   logic [15:0] rd_val;
   always_comb begin
      rd_val = 16'h0000;
      unique case (idx)
         `PGS_IDX_GIG_STATUS: begin
            rd_val = {st_ff.ms_fault, gig_evt.ms_master, gig_evt.local_rx_ok,
                      gig_evt.remote_rx_ok, gig_evt.lp_1000_fd, gig_evt.lp_1000_hd,
                      2'h0, idle_cnt};
         end
         `PGS_IDX_ACC_CTRL: begin
            rd_val = {st_ff.fn, 9'h000, st_ff.devad};
         end
         `PGS_IDX_ADDR_DATA: begin
            rd_val = is_data_fn(st_ff.fn) ? mmd_rdata : st_ff.mmd_addr;
         end
         `PGS_IDX_GIG_EXT1: begin
            rd_val = `PGS_EXT1_VALUE;
         end
         `PGS_IDX_FAST_EXT: begin
            if (page0) begin
               rd_val = {fast_evt.desc_locked, fast_flags[5:4], fast_evt.link_up,
                         fast_flags[3:0], 8'h00};
            end
         end
         `PGS_IDX_PAGE_SEL: begin
            rd_val = {14'h0000, st_ff.page};
         end
         default: rd_val = 16'h0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   logic [15:0] ctrl_w;
   logic [15:0] ad_w;
   logic data_acc;
   assign ctrl_w = lane_merge({st_ff.fn, 9'h000, st_ff.devad}, wb_dat_i, wb_sel_i);
   assign ad_w = lane_merge(st_ff.addr_data, wb_dat_i, wb_sel_i);
   assign data_acc = req_new && idx == `PGS_IDX_ADDR_DATA && is_data_fn(st_ff.fn);

   always_comb begin
      nxt_st = st_ff;
      nxt_st.ack = req_new;
      nxt_st.req.rd = 1'b0;
      nxt_st.req.wr = 1'b0;
      if (req_new) begin
         nxt_st.rdat = wb_we_i ? 32'h0000_0000 : {16'h0000, rd_val};
      end
      // fault stays until a read, and a new fault on that read still lands
      if (clr_gig) begin
         nxt_st.ms_fault = 1'b0;
      end
      if (gig_evt.ms_fault) begin
         nxt_st.ms_fault = 1'b1;
      end
      if (is_wr && idx == `PGS_IDX_ACC_CTRL) begin
         nxt_st.fn = ctrl_w[`PGS_FN_HI:`PGS_FN_LO];
         nxt_st.devad = ctrl_w[`PGS_DEVAD_HI:`PGS_DEVAD_LO];
      end
      if (is_wr && idx == `PGS_IDX_PAGE_SEL && wb_sel_i[0] && wb_dat_i[1:0] <= `PGS_PAGE_MAX) begin
         nxt_st.page = wb_dat_i[1:0];
      end
      if (is_wr && idx == `PGS_IDX_ADDR_DATA) begin
         nxt_st.addr_data = ad_w;
         if (!is_data_fn(st_ff.fn)) begin
            nxt_st.mmd_addr = ad_w;
         end
      end
      if (data_acc) begin
         nxt_st.req.addr = st_ff.mmd_addr;
         nxt_st.req.devad = st_ff.devad;
         nxt_st.req.rd = !wb_we_i;
         nxt_st.req.wr = wb_we_i;
         nxt_st.req.wdata = ad_w;
         // write increment is honoured here though the manager may not count on it
         unique case (st_ff.fn)
            `PGS_FN_DATA_INC_RW: nxt_st.mmd_addr = st_ff.mmd_addr + 16'h0001;
            `PGS_FN_DATA_INC_WR: if (wb_we_i) nxt_st.mmd_addr = st_ff.mmd_addr + 16'h0001;
            default: nxt_st.mmd_addr = st_ff.mmd_addr;
         endcase
      end
      // outside a pulse the request word shows the held address, so a data read
      // sees the device answer for the current place before its taking edge
      if (!data_acc) begin
         nxt_st.req.addr = nxt_st.mmd_addr;
         nxt_st.req.devad = nxt_st.devad;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.addr_data <= `PGS_RST_ADDR_DATA;
         st_ff.fn <= `PGS_FN_ADDR;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign wb_ack_o = st_ff.ack;
   assign wb_dat_o = st_ff.rdat;
   assign mmd_req = st_ff.req;
   assign page_sel = st_ff.page;

   ////////////////////////////////////////////////////////////////////////
   ack_one_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && req_new |=> wb_ack_o ##1 (!wb_ack_o || !ce)) else $error("ack not one cycle after request");
   fault_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && gig_evt.ms_fault |=> st_ff.ms_fault) else $error("fault bit failed to latch");
   fault_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && st_ff.ms_fault && !clr_gig |=> st_ff.ms_fault) else $error("fault bit dropped without read");
   ext1_fixed_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_GIG_EXT1 |=> wb_dat_o == 32'h0000_3000) else $error("ext1 value wrong");
   fast_page_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_FAST_EXT && !page0 |=> wb_dat_o == 32'h0) else $error("fast ext seen off page 0");
   gig_live_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_GIG_STATUS |=> wb_dat_o[14:10] == $past({gig_evt.ms_master,
         gig_evt.local_rx_ok, gig_evt.remote_rx_ok, gig_evt.lp_1000_fd, gig_evt.lp_1000_hd}))
      else $error("gig status live bits wrong");
   rd_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && data_acc && !wb_we_i && st_ff.fn == `PGS_FN_DATA_INC_RW |=>
         st_ff.mmd_addr == $past(st_ff.mmd_addr) + 16'h0001)
      else $error("read increment missing");
   no_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && data_acc && st_ff.fn == `PGS_FN_DATA |=> $stable(st_ff.mmd_addr)) else $error("address moved on plain data");
   rd_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && clr_fast && (fast_evt & 8'h6f) == 8'h00 ##1 ce |-> fast_flags == 6'h00)
      else $error("flags not cleared by read");
   cnt_sat_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !clr_gig && idle_cnt == 8'hff |=> idle_cnt == 8'hff) else $error("idle counter wrapped");
   reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
      wb_dat_o[31:16] == 16'h0000) else $error("upper read bits not zero");

   ////////////////////////////////////////////////////////////////////////
   // gigabit status word against the inputs, fault bit and idle count seen at the taking edge
   master_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_GIG_STATUS |=> wb_dat_o[14] == $past(gig_evt.ms_master))
      else $error("master bit wrong");
   local_rx_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_GIG_STATUS |=> wb_dat_o[13] == $past(gig_evt.local_rx_ok))
      else $error("local receiver bit wrong");
   remote_rx_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_GIG_STATUS |=> wb_dat_o[12] == $past(gig_evt.remote_rx_ok))
      else $error("remote receiver bit wrong");
   lp_ability_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_GIG_STATUS |=>
         wb_dat_o[11:10] == $past({gig_evt.lp_1000_fd, gig_evt.lp_1000_hd}))
      else $error("partner ability bits wrong");
   fault_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_GIG_STATUS |=> wb_dat_o[15] == $past(st_ff.ms_fault))
      else $error("fault bit read wrong");
   idle_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_GIG_STATUS |=> wb_dat_o[7:0] == $past(idle_cnt))
      else $error("idle count read wrong");
   gig_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_GIG_STATUS |=> wb_dat_o[9:8] == 2'h0)
      else $error("gig status reserved bits set");

   ////////////////////////////////////////////////////////////////////////
   // read-clear and counting of the fault bit and idle counter
   fault_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && clr_gig && !gig_evt.ms_fault |=> !st_ff.ms_fault)
      else $error("fault bit kept after read");
   cnt_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && clr_gig && !gig_evt.idle_err |=> idle_cnt == 8'h00)
      else $error("idle count kept after read");
   cnt_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !clr_gig && gig_evt.idle_err && idle_cnt != 8'hff |=> idle_cnt == $past(idle_cnt) + 8'h01)
      else $error("idle count missed an error");
   cnt_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !clr_gig && !gig_evt.idle_err |=> $stable(idle_cnt))
      else $error("idle count moved without error");

   ////////////////////////////////////////////////////////////////////////
   // access control and the address/data window
   ctrl_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_ACC_CTRL |=> wb_dat_o[13:5] == 9'h000)
      else $error("control reserved bits set");
   fn_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_wr && idx == `PGS_IDX_ACC_CTRL && wb_sel_i[1] |=> st_ff.fn == $past(wb_dat_i[15:14]))
      else $error("function field not written");
   devad_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_wr && idx == `PGS_IDX_ACC_CTRL && wb_sel_i[0] |=> st_ff.devad == $past(wb_dat_i[4:0]))
      else $error("device field not written");
   addr_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_wr && idx == `PGS_IDX_ADDR_DATA && st_ff.fn == `PGS_FN_ADDR && wb_sel_i[1:0] == 2'h3 |=>
         st_ff.mmd_addr == $past(wb_dat_i[15:0]))
      else $error("device address not written");
   addr_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_ADDR_DATA && st_ff.fn == `PGS_FN_ADDR |=>
         wb_dat_o[15:0] == $past(st_ff.mmd_addr))
      else $error("address mode read wrong");
   data_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_ADDR_DATA && st_ff.fn != `PGS_FN_ADDR |=>
         wb_dat_o[15:0] == $past(mmd_rdata))
      else $error("data mode read wrong");
   wr_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && data_acc && wb_we_i && st_ff.fn == `PGS_FN_DATA_INC_WR |=>
         st_ff.mmd_addr == $past(st_ff.mmd_addr) + 16'h0001)
      else $error("write increment missing");
   rd_noinc_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && data_acc && !wb_we_i && st_ff.fn == `PGS_FN_DATA_INC_WR |=> $stable(st_ff.mmd_addr))
      else $error("address moved on write-only increment read");
   req_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && data_acc |=> (mmd_req.rd || mmd_req.wr) && mmd_req.addr == $past(st_ff.mmd_addr))
      else $error("device request missing");
   req_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !data_acc |=> !mmd_req.rd && !mmd_req.wr)
      else $error("device request without data access");

   ////////////////////////////////////////////////////////////////////////
   // fast status extension: live bits, flags and page visibility
   desc_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_FAST_EXT && page0 |=> wb_dat_o[15] == $past(fast_evt.desc_locked))
      else $error("lock bit wrong");
   link_live_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_FAST_EXT && page0 |=> wb_dat_o[12] == $past(fast_evt.link_up))
      else $error("link bit wrong");
   fast_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_FAST_EXT |=> wb_dat_o[7:0] == 8'h00)
      else $error("fast reserved bits set");
   lock_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && fast_evt.lock_err |=> fast_flags[5]) else $error("lock error flag missed");
   disc_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && fast_evt.link_disc |=> fast_flags[4]) else $error("disconnect flag missed");
   rx_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && fast_evt.rx_err |=> fast_flags[3]) else $error("receive error flag missed");
   tx_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && fast_evt.tx_err |=> fast_flags[2]) else $error("transmit error flag missed");
   ssd_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && fast_evt.ssd_err |=> fast_flags[1]) else $error("start delimiter flag missed");
   esd_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && fast_evt.esd_err |=> fast_flags[0]) else $error("end delimiter flag missed");
   page_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_wr && idx == `PGS_IDX_PAGE_SEL && wb_dat_i[1:0] > `PGS_PAGE_MAX |=> $stable(page_sel))
      else $error("illegal page accepted");
   ext1_page_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_rd && idx == `PGS_IDX_GIG_EXT1 && !page0 |=> wb_dat_o[15:0] == 16'h3000)
      else $error("ext1 hidden off page 0");

   ////////////////////////////////////////////////////////////////////////
   // bus side: clock enable freezes, writes answer zero
   ce_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
      !ce |=> $stable(st_ff)) else $error("state moved while disabled");
   wr_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      ce && is_wr |=> wb_dat_o == 32'h0000_0000) else $error("write returned data");
endmodule

// ---- verilog/pgs_sticky.sv ----
// sticky flag and saturating counter cluster, cleared on read
`timescale 1ns/1ps
module pgs_sticky #(
   parameter int CNT_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [5:0] evt,
   input wire logic cnt_inc,
   input wire logic clr_flags,
   input wire logic clr_cnt,
   output logic [5:0] flags,
   output logic [CNT_W-1:0] count
);
   import pgs_pkg::*;
   typedef struct packed {
      logic [5:0] flags;
      logic [CNT_W-1:0] count;
   } pgs_stk_s;
   pgs_stk_s st_ff, nxt_st;

   always_comb begin
      nxt_st = st_ff;
      // event in the same cycle as the read-clear survives
      nxt_st.flags = (clr_flags ? 6'h00 : st_ff.flags) | evt;
      if (clr_cnt) begin
         nxt_st.count = cnt_inc ? CNT_W'(1) : '0;
      end else if (cnt_inc && st_ff.count != {CNT_W{1'b1}}) begin
         // saturate rather than wrap, so a burst never reads as few errors
         nxt_st.count = st_ff.count + CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign flags = st_ff.flags;
   assign count = st_ff.count;
endmodule
